// file: apdc_defs.vh
`ifndef APDC_DEFS_VH
`define APDC_DEFS_VH
`define APDC_ADDR_CTRL 12'h000
`define APDC_ADDR_FBDIV 12'h004
`define APDC_ADDR_POST 12'h008
`define APDC_ADDR_STAT 12'h00c
`define APDC_CTRL_EN_BIT 0
`define APDC_CTRL_SRC_BIT 1
`define APDC_CTRL_PRE_LSB 8
`define APDC_CTRL_PRE_MSB 11
`define APDC_POST1_LSB 0
`define APDC_POST1_MSB 2
`define APDC_POST2_LSB 4
`define APDC_POST2_MSB 6
`define APDC_RST_PRE 4'h1
`define APDC_RST_FB 8'h01
`define APDC_RST_POST 3'h1
`define APDC_SETTLE_NS 2000
`define APDC_CLK_NS 50
`define APDC_SETTLE_CYC ((`APDC_SETTLE_NS + `APDC_CLK_NS - 1) / `APDC_CLK_NS)
`endif

// file: apdc_divider.v
`timescale 1ns/1ps
// divides an enable-pulse stream by ratio; ratio 0 treated as 1
module apdc_divider (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [7:0] ratio,
   input wire tick_in,
   output reg tick_out
);
   reg [7:0] count;
   wire [7:0] limit;
   assign limit = (ratio == 8'h00) ? 8'h01 : ratio;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
         tick_out <= 1'b0;
      end else if (!run) begin
         count <= 8'h00;
         tick_out <= 1'b0;
      end else if (tick_in) begin
         if (count + 8'h01 >= limit) begin
            count <= 8'h00;
            tick_out <= 1'b1;
         end else begin
            count <= count + 8'h01;
            tick_out <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0;
      end
   end
endmodule

// file: apdc_top.v
`timescale 1ns/1ps
`include "apdc_defs.vh"
// Overview of operation
// [R1] vco rate is input times multiplier over prescaler
// [R2] output is vco over both postscalers
// [R3] 8-bit multiplier, 4-bit prescaler used directly
// [R4] two 3-bit postscalers cascaded after vco
// [R5] loop runs only with enable and request
// [R6] source select one picks internal oscillator
// [R7] output held off until vco settled
module apdc_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire ext_ref_tick,
   input wire internal_fast_rc_osc_tick,
   input wire clock_request,
   output reg aux_vco_tick,
   output reg aux_loop_output_tick,
   output reg aux_loop_running,
   output reg aux_loop_locked
);
   localparam ST_OFF = 2'b00;
   localparam ST_SETTLE = 2'b01;
   localparam ST_LOCKED = 2'b10;
   localparam [15:0] SETTLE_CYC = `APDC_SETTLE_CYC;

   reg aux_loop_enable;
   reg internal_osc_source_select;
   reg [3:0] input_prescaler;
   reg [7:0] feedback_multiplier;
   reg [2:0] first_postscaler;
   reg [2:0] second_postscaler;
   reg [31:0] next_prdata;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [15:0] settle_count;
   reg [7:0] mult_count;
   reg vco_pulse;
   wire ref_tick;
   wire pfd_tick;
   wire post1_tick;
   wire post2_tick;
   wire run;
   wire wr;
   wire rd;
   wire known;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign known = (paddr == `APDC_ADDR_CTRL) || (paddr == `APDC_ADDR_FBDIV) ||
                  (paddr == `APDC_ADDR_POST) || (paddr == `APDC_ADDR_STAT);
   assign ref_tick = internal_osc_source_select ? internal_fast_rc_osc_tick
                                                : ext_ref_tick; // [R6]
   assign run = aux_loop_enable & clock_request; // [R5]

   // one process per writable register address keeps each write decode independent
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_loop_enable <= 1'b0;
         internal_osc_source_select <= 1'b0;
         input_prescaler <= `APDC_RST_PRE;
      end else if (wr && paddr == `APDC_ADDR_CTRL) begin
         aux_loop_enable <= pwdata[`APDC_CTRL_EN_BIT];
         internal_osc_source_select <= pwdata[`APDC_CTRL_SRC_BIT];
         input_prescaler <= pwdata[`APDC_CTRL_PRE_MSB:`APDC_CTRL_PRE_LSB]; // [R3]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feedback_multiplier <= `APDC_RST_FB;
      end else if (wr && paddr == `APDC_ADDR_FBDIV) begin
         feedback_multiplier <= pwdata[7:0]; // [R3]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_postscaler <= `APDC_RST_POST;
         second_postscaler <= `APDC_RST_POST;
      end else if (wr && paddr == `APDC_ADDR_POST) begin
         first_postscaler <= pwdata[`APDC_POST1_MSB:`APDC_POST1_LSB]; // [R4]
         second_postscaler <= pwdata[`APDC_POST2_MSB:`APDC_POST2_LSB]; // [R4]
      end
   end

   // read mux; unmapped offsets read as zero
   always @* begin
      next_prdata = 32'h00000000;
      case (paddr)
         `APDC_ADDR_CTRL: begin
            next_prdata = {20'h00000, input_prescaler, 6'h00,
                           internal_osc_source_select, aux_loop_enable};
         end
         `APDC_ADDR_FBDIV: begin
            next_prdata = {24'h000000, feedback_multiplier};
         end
         `APDC_ADDR_POST: begin
            next_prdata = {25'h0000000, second_postscaler, 1'b0, first_postscaler};
         end
         `APDC_ADDR_STAT: begin
            next_prdata = {30'h00000000, aux_loop_locked, aux_loop_running};
         end
         default: begin
            next_prdata = 32'h00000000;
         end
      endcase
   end

   // zero-wait slave: ready in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~known;
         if (rd) begin
            prdata <= next_prdata;
         end
      end
   end

   // prescaler divides the reference down to the phase-compare rate
   apdc_divider u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .ratio({4'h0, input_prescaler}),
      .tick_in(ref_tick),
      .tick_out(pfd_tick)
   ); // [R1]

   // behavioural vco: one compare pulse releases feedback_multiplier vco pulses,
   // one per pclk; ratio holds only while the vco rate stays below pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult_count <= 8'h00;
         vco_pulse <= 1'b0;
      end else if (!run) begin
         mult_count <= 8'h00;
         vco_pulse <= 1'b0;
      end else if (pfd_tick) begin
         mult_count <= feedback_multiplier; // [R1]
         vco_pulse <= 1'b0;
      end else if (mult_count != 8'h00) begin
         mult_count <= mult_count - 8'h01;
         vco_pulse <= 1'b1;
      end else begin
         vco_pulse <= 1'b0;
      end
   end

   apdc_divider u_post1 (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .ratio({5'h00, first_postscaler}),
      .tick_in(vco_pulse),
      .tick_out(post1_tick)
   ); // [R4]

   apdc_divider u_post2 (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .ratio({5'h00, second_postscaler}),
      .tick_in(post1_tick),
      .tick_out(post2_tick)
   ); // [R2]

   always @* begin
      next_state = state;
      case (state)
         ST_OFF: if (run) next_state = ST_SETTLE;
         ST_SETTLE: begin
            if (!run) next_state = ST_OFF;
            else if (settle_count == 16'h0001) next_state = ST_LOCKED;
         end
         ST_LOCKED: if (!run) next_state = ST_OFF;
         default: next_state = ST_OFF;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_OFF;
         settle_count <= 16'h0000;
      end else begin
         state <= next_state;
         if (state == ST_OFF && run)
            settle_count <= SETTLE_CYC; // [R7]
         else if (state == ST_SETTLE && settle_count != 16'h0000)
            settle_count <= settle_count - 16'h0001;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_vco_tick <= 1'b0;
         aux_loop_output_tick <= 1'b0;
         aux_loop_running <= 1'b0;
         aux_loop_locked <= 1'b0;
      end else begin
         aux_loop_running <= run; // [R5]
         aux_loop_locked <= (next_state == ST_LOCKED);
         aux_vco_tick <= vco_pulse & run;
         aux_loop_output_tick <= post2_tick & (state == ST_LOCKED); // [R7]
      end
   end
endmodule

// file: apdc_asserts.sv
`timescale 1ns/1ps
module apdc_asserts (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   input logic clock_request,
   input logic aux_vco_tick,
   input logic aux_loop_output_tick,
   input logic aux_loop_running,
   input logic aux_loop_locked
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_run_on_request: assert property (aux_loop_running |-> $past(clock_request))
      else $error("loop running without a request");
   a_lock_not_early: assert property ($rose(aux_loop_running) |-> !aux_loop_locked[*8])
      else $error("locked too soon after start");
   a_lock_after_run: assert property ($rose(aux_loop_locked) |-> $past(aux_loop_running, 8))
      else $error("locked without settling run");
   a_out_when_locked: assert property (aux_loop_output_tick |-> $past(aux_loop_locked))
      else $error("output pulse while unlocked");
   a_vco_when_run: assert property (aux_vco_tick |-> $past(aux_loop_running))
      else $error("vco pulse while stopped");
   a_ready_one_cycle: assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready not a single access pulse");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   c_locked: cover property ($rose(aux_loop_locked));
   c_output: cover property (aux_loop_output_tick);
   c_error: cover property (pslverr);
endmodule
bind apdc_top apdc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .clock_request, .aux_vco_tick, .aux_loop_output_tick, .aux_loop_running, .aux_loop_locked);

// file: apdc_tb_top.sv
`timescale 1ns/1ps
`include "apdc_defs.vh"
module apdc_tb_top;
   logic pclk, presetn, psel, penable, pwrite, ext_ref_tick, internal_fast_rc_osc_tick;
   logic clock_request, ref_on, osc_on, pready, pslverr, vco, outk, run, lock, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_total, n_tests, nv, no, cnt, i, k;
   apdc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_ref_tick(ext_ref_tick),
      .internal_fast_rc_osc_tick(internal_fast_rc_osc_tick), .clock_request(clock_request),
      .aux_vco_tick(vco), .aux_loop_output_tick(outk), .aux_loop_running(run),
      .aux_loop_locked(lock));
   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   // reference every 20 cycles: bursts never straddle a window edge
   always @(posedge pclk) begin
      cnt <= (cnt + 1) % 20;
      ext_ref_tick <= ref_on && cnt == 0;
      internal_fast_rc_osc_tick <= osc_on && cnt == 0;
      if (vco === 1'b1) nv <= nv + 1;
      if (outk === 1'b1) no <= no + 1;
   end
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, x);
      n_tests++;
      if (s !== x) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk(0, 1);
         test_done;
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
      apb(0, a, 0);
      chk(q, x);
      chk(e, ex);
   endtask
   // counts are whole multiples of post1*post2, so divider phase cannot skew them
   task window(input logic [31:0] xv, xo);
      int v0, o0;
      while (cnt != 10) @(posedge pclk);
      v0 = nv;
      o0 = no;
      repeat (800) @(posedge pclk);
      chk(nv - v0, xv);
      chk(no - o0, xo);
   endtask
   initial begin
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      clock_request = 0;
      ref_on = 1;
      osc_on = 0;
      ext_ref_tick = 0;
      internal_fast_rc_osc_tick = 0;
      cnt = 0;
      nv = 0;
      no = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      rd(`APDC_ADDR_CTRL, 32'h100, 0);
      rd(`APDC_ADDR_FBDIV, 32'h1, 0);
      rd(`APDC_ADDR_POST, 32'h11, 0);
      rd(12'h010, 0, 1);
      apb(1, `APDC_ADDR_FBDIV, 32'h3);
      apb(1, `APDC_ADDR_POST, 32'h32);
      rd(`APDC_ADDR_POST, 32'h32, 0);
      for (int s = 0; s < 3; s++) begin
         osc_on <= (s == 2);
         apb(1, `APDC_ADDR_CTRL, s > 0 ? 32'h203 : 32'h201);
         repeat (50) @(posedge pclk);
         chk(run, 0);
         clock_request <= 1;
         i = 0;
         while (lock !== 1'b1 && i < 200) begin
            @(posedge pclk);
            i++;
         end
         chk(i > 40 && i < 200, 1);
         if (i >= 200) test_done;
         rd(`APDC_ADDR_STAT, 32'h3, 0);
         window(s == 1 ? 0 : 60, s == 1 ? 0 : 10);
         clock_request <= 0;
         repeat (5) @(posedge pclk);
      end
      test_done;
   end
endmodule
